// *** src/rrs_exec.v ***
// Execution unit for literal return, rotate right, return and standby
`timescale 1ns/1ps
`include "rrs_map.vh"

// How it works
// RULE1 - Literal return loads literal into working register
// RULE2 - Literal return pops stack, two cycles
// RULE3 - Rotate right through carry, carry only
// RULE4 - Destination bit picks working or file
// RULE5 - Plain return pops stack, two cycles
// RULE6 - Standby clears power-down status bit
// RULE7 - Standby sets time-out status bit
// RULE8 - Standby clears watchdog counter and prescaler
// RULE9 - Standby then halts, stops oscillator
// RULE10 - Plain return encoded 00 0000 0000 1000
module rrs_exec (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rstn_in,
  // Instruction issue
  input  wire        instr_valid_in,
  input  wire [13:0] instr_in,
  output wire        instr_ready_out,
  // Call side of the return stack
  input  wire        push_in,
  input  wire [10:0] push_addr_in,
  // Wake from standby
  input  wire        wake_in,
  // File register read data and write port
  input  wire [7:0]  file_rdata_in,
  output reg  [6:0]  file_addr_out,
  output reg  [7:0]  file_wdata_out,
  output reg         file_we_out,
  // Core state
  output reg  [7:0]  working_reg_out,
  output reg         carry_out,
  output reg  [10:0] pc_out,
  output reg         pc_load_out,
  output reg         timeout_status_bit_out,
  output reg         powerdown_status_bit_out,
  output reg  [7:0]  watchdog_counter_out,
  output reg  [7:0]  watchdog_prescaler_out,
  output reg         sleep_out,
  output reg         osc_stop_out
);

  // One-hot sequencer states
  localparam ST_RUN   = 3'b001;
  localparam ST_POP   = 3'b010;
  localparam ST_SLEEP = 3'b100;

  // Reset synchroniser
  reg                         rst_meta;
  reg                         rst_sync;
  // Sequencer and return stack
  reg  [2:0]                  state;
  reg  [2:0]                  next_state;
  reg  [10:0]                 stack_mem [0:`RRS_STACK_DEPTH-1];
  reg  [`RRS_STACK_PTR_W-1:0] sp;
  reg  [`RRS_STACK_PTR_W-1:0] next_sp;
  // Next values of the registered outputs
  reg  [7:0]                  next_working;
  reg                         next_carry;
  reg  [10:0]                 next_pc;
  reg                         next_pc_load;
  reg  [6:0]                  next_file_addr;
  reg  [7:0]                  next_file_wdata;
  reg                         next_file_we;
  reg                         next_timeout;
  reg                         next_powerdown;
  reg  [7:0]                  next_wd_count;
  reg  [7:0]                  next_wd_presc;
  reg                         next_sleep;
  reg                         next_osc_stop;

  // Decode and helpers
  wire                        rstn;
  wire                        in_run;
  wire                        take;
  wire                        push_ok;
  wire                        is_litret;
  wire                        is_rotr;
  wire                        is_return;
  wire                        is_sleep;
  wire                        wd_wrap;
  wire [7:0]                  rot;
  wire [`RRS_STACK_PTR_W-1:0] sp_dec;
  wire [`RRS_STACK_PTR_W-1:0] sp_inc;

  assign rstn      = rst_sync;
  assign in_run    = (state == ST_RUN);
  // Nothing is accepted until the synchronised reset has let go
  assign take      = instr_valid_in && in_run && rstn;
  // A push only counts when no instruction is taken in that cycle
  assign push_ok   = push_in && in_run && !take && rstn;
  assign is_litret = (instr_in[13:10] == `RRS_OP_LITRET_HI); // [RULE1]
  assign is_rotr   = (instr_in[13:8] == `RRS_OP_ROTR_HI);    // [RULE3]
  assign is_return = (instr_in == `RRS_OP_RETURN);           // [RULE10]
  assign is_sleep  = (instr_in == `RRS_OP_SLEEP);            // [RULE6]
  assign wd_wrap   = &watchdog_prescaler_out;
  assign rot       = {carry_out, file_rdata_in[7:1]};        // [RULE3]
  assign sp_dec    = sp - 1'b1;
  assign sp_inc    = sp + 1'b1;

  // Busy in reset, in the second cycle of returns and during standby
  assign instr_ready_out = in_run && rstn;

  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Stack storage has no reset; only the pointer does
  genvar g;
  generate
    for (g = 0; g < `RRS_STACK_DEPTH; g = g + 1) begin : g_stack
      localparam [`RRS_STACK_PTR_W-1:0] IDX = g;
      always @(posedge clk_sys_in) begin
        if (push_ok && (sp == IDX))
          stack_mem[g] <= push_addr_in;
      end
    end
  endgenerate

  always @* begin
    next_state      = state;
    next_sp         = sp;
    next_working    = working_reg_out;
    next_carry      = carry_out;
    next_pc         = pc_out;
    next_pc_load    = 1'b0;
    next_file_addr  = file_addr_out;
    next_file_wdata = file_wdata_out;
    next_file_we    = 1'b0;
    next_timeout    = timeout_status_bit_out;
    next_powerdown  = powerdown_status_bit_out;
    next_wd_count   = watchdog_counter_out;
    next_wd_presc   = watchdog_prescaler_out;
    next_sleep      = sleep_out;
    next_osc_stop   = osc_stop_out;
    case (state)
      ST_RUN: begin
        // Watchdog counts only in ST_RUN; it holds in the pop cycle and in standby
        next_wd_presc = watchdog_prescaler_out + 8'h01;
        if (wd_wrap)
          next_wd_count = watchdog_counter_out + 8'h01;
        if (push_ok)
          next_sp = sp_inc;
        if (take && is_litret) begin
          next_working = instr_in[7:0];                // [RULE1]
          next_state   = ST_POP;                       // [RULE2]
        end else if (take && is_return) begin
          next_state = ST_POP;                         // [RULE5]
        end else if (take && is_rotr) begin
          next_carry = file_rdata_in[0];               // [RULE3]
          if (instr_in[`RRS_DEST_BIT]) begin
            next_file_addr  = instr_in[6:0];           // [RULE4]
            next_file_wdata = rot;                     // [RULE4]
            next_file_we    = 1'b1;                    // [RULE4]
          end else begin
            next_working = rot;                        // [RULE4]
          end
        end else if (take && is_sleep) begin
          next_powerdown = 1'b0;                       // [RULE6]
          next_timeout   = 1'b1;                       // [RULE7]
          next_wd_count  = `RRS_WATCHDOG_CLEAR;        // [RULE8]
          next_wd_presc  = `RRS_PRESC_CLEAR;           // [RULE8]
          next_sleep     = 1'b1;                       // [RULE9]
          next_osc_stop  = 1'b1;                       // [RULE9]
          next_state     = ST_SLEEP;                   // [RULE9]
        end
      end
      ST_POP: begin
        // Second cycle: pop and load the return address
        next_pc      = stack_mem[sp_dec];              // [RULE2] [RULE5]
        next_pc_load = 1'b1;
        next_sp      = sp_dec;
        next_state   = ST_RUN;
      end
      ST_SLEEP: begin
        // Watchdog frozen while the oscillator is stopped
        if (wake_in) begin
          next_sleep    = 1'b0;
          next_osc_stop = 1'b0;
          next_state    = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      state                    <= ST_RUN;
      sp                       <= {`RRS_STACK_PTR_W{1'b0}};
      working_reg_out          <= 8'h00;
      carry_out                <= 1'b0;
      pc_out                   <= 11'h000;
      pc_load_out              <= 1'b0;
      file_addr_out            <= 7'h00;
      file_wdata_out           <= 8'h00;
      file_we_out              <= 1'b0;
      timeout_status_bit_out   <= 1'b1;
      powerdown_status_bit_out <= 1'b1;
      watchdog_counter_out     <= 8'h00;
      watchdog_prescaler_out   <= 8'h00;
      sleep_out                <= 1'b0;
      osc_stop_out             <= 1'b0;
    end else begin
      state                    <= next_state;
      sp                       <= next_sp;
      working_reg_out          <= next_working;
      carry_out                <= next_carry;
      pc_out                   <= next_pc;
      pc_load_out              <= next_pc_load;
      file_addr_out            <= next_file_addr;
      file_wdata_out           <= next_file_wdata;
      file_we_out              <= next_file_we;
      timeout_status_bit_out   <= next_timeout;
      powerdown_status_bit_out <= next_powerdown;
      watchdog_counter_out     <= next_wd_count;
      watchdog_prescaler_out   <= next_wd_presc;
      sleep_out                <= next_sleep;
      osc_stop_out             <= next_osc_stop;
    end
  end

endmodule

// *** src/rrs_map.vh ***
// Opcode patterns, field positions and timing for the return/rotate/standby unit
`ifndef RRS_MAP_VH
`define RRS_MAP_VH
`define RRS_OP_LITRET_HI  4'hd
`define RRS_OP_ROTR_HI    6'h0c
`define RRS_OP_RETURN     14'h0008
`define RRS_OP_SLEEP      14'h0063
`define RRS_DEST_BIT      7
`define RRS_ADDR_W        7
`define RRS_STACK_DEPTH   8
`define RRS_STACK_PTR_W   3
`define RRS_RETURN_CYCLES 2
`define RRS_WATCHDOG_CLEAR 8'h00
`define RRS_PRESC_CLEAR   8'h00
`endif

// *** test/rrs_exec_properties.sv ***
// Port assertions for rrs_exec
`timescale 1ns/1ps
module rrs_exec_chk (
  input wire clk_sys_in, rstn_in, instr_valid_in, instr_ready_out,
  input wire file_we_out, carry_out, pc_load_out, sleep_out, osc_stop_out,
  input wire wake_in,
  input wire timeout_status_bit_out, powerdown_status_bit_out,
  input wire [13:0] instr_in,
  input wire [7:0] file_rdata_in, file_wdata_out, working_reg_out,
  input wire [7:0] watchdog_counter_out, watchdog_prescaler_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire t = instr_valid_in && instr_ready_out;
  wire l = t && instr_in[13:10] == 4'hd;
  wire r = t && instr_in[13:8] == 6'h0c;
  wire s = t && instr_in == 14'h0063;
  // Rotated value lands in one place only, picked by the write strobe
  wire [7:0] v = file_we_out ? file_wdata_out : working_reg_out;
  sequence s_pop; !instr_ready_out ##1 pc_load_out; endsequence
  property p_lit; l |=> working_reg_out == $past(instr_in[7:0]); endproperty
  a_lit: assert property (p_lit) else $error("literal");
  property p_litst; l |=> $stable(carry_out)
    && $stable(timeout_status_bit_out)
    && $stable(powerdown_status_bit_out); endproperty
  a_litst: assert property (p_litst) else $error("lit flags");
  property p_lpop; l |=> s_pop; endproperty
  a_lpop: assert property (p_lpop) else $error("pop");
  property p_rot; r |=> carry_out == $past(file_rdata_in[0]); endproperty
  a_rot: assert property (p_rot) else $error("carry");
  property p_rotst; r |=> $stable(timeout_status_bit_out)
    && $stable(powerdown_status_bit_out); endproperty
  a_rotst: assert property (p_rotst) else $error("rot flags");
  property p_dst; r |=> file_we_out == $past(instr_in[7])
    && v == {$past(carry_out), $past(file_rdata_in[7:1])}; endproperty
  a_dst: assert property (p_dst) else $error("dest");
  property p_ret; t && instr_in == 14'h0008 |=> s_pop; endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_st; s |=> !powerdown_status_bit_out && timeout_status_bit_out
    && $stable(carry_out); endproperty
  a_st: assert property (p_st) else $error("status");
  property p_wdt; s |=> {watchdog_counter_out, watchdog_prescaler_out}
    == 16'h0000; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog");
  property p_halt; s |=> sleep_out && osc_stop_out && !instr_ready_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_wake; sleep_out && wake_in |=> !sleep_out && !osc_stop_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
endmodule
bind rrs_exec rrs_exec_chk rrs_exec_chk_i (.*);

// *** test/rrs_exec_test.sv ***
// Random and corner stimulus for rrs_exec
`timescale 1ns/1ps
module rrs_exec_test;
  reg clk_sys_in = 0, rstn_in = 0, instr_valid_in = 0, push_in = 0;
  reg wake_in = 0, c = 0;
  reg [13:0] instr_in = 0;
  reg [10:0] push_addr_in = 0;
  reg [7:0] file_rdata_in = 0, w = 0, k, y;
  wire instr_ready_out, file_we_out, carry_out, pc_load_out, sleep_out;
  wire osc_stop_out, timeout_status_bit_out, powerdown_status_bit_out;
  wire [6:0] file_addr_out;
  wire [7:0] file_wdata_out, working_reg_out;
  wire [7:0] watchdog_counter_out, watchdog_prescaler_out;
  wire [10:0] pc_out;
  integer seed = 32'h6fb74545, bad_count = 0, comparisons = 0, n = 0, i;
  rrs_exec rrs_exec_i (
    .clk_sys_in               (clk_sys_in),
    .rstn_in                  (rstn_in),
    .instr_valid_in           (instr_valid_in),
    .instr_in                 (instr_in),
    .instr_ready_out          (instr_ready_out),
    .push_in                  (push_in),
    .push_addr_in             (push_addr_in),
    .wake_in                  (wake_in),
    .file_rdata_in            (file_rdata_in),
    .file_addr_out            (file_addr_out),
    .file_wdata_out           (file_wdata_out),
    .file_we_out              (file_we_out),
    .working_reg_out          (working_reg_out),
    .carry_out                (carry_out),
    .pc_out                   (pc_out),
    .pc_load_out              (pc_load_out),
    .timeout_status_bit_out   (timeout_status_bit_out),
    .powerdown_status_bit_out (powerdown_status_bit_out),
    .watchdog_counter_out     (watchdog_counter_out),
    .watchdog_prescaler_out   (watchdog_prescaler_out),
    .sleep_out                (sleep_out),
    .osc_stop_out             (osc_stop_out)
  );
  always #10 clk_sys_in = ~clk_sys_in;
  // The sequence needs about 86 cycles
  always @(posedge clk_sys_in) if (++n == 900) begin
    bad_count++;
    tally_and_finish;
  end
  function [8:0] rot(input cy, input [7:0] f);
    rot = {f[0], cy, f[7:1]};
  endfunction
  task tick; @(posedge clk_sys_in); #1; endtask
  task chk(input [31:0] got, want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, got, want);
    end
  endtask
  task go(input [13:0] op);
    instr_valid_in = 1; instr_in = op; file_rdata_in = $random(seed); tick;
  endtask
  task tally_and_finish;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) tick;
    rstn_in = 1;
    repeat (3) tick;
    // Back-to-back rotates; the first two carry address 127, only the second writes the file
    for (i = 0; i < 40; i++) begin
      k = i < 2 ? {i[0], 7'h7f} : $random(seed);
      go({6'h0c, k});
      {c, y} = rot(c, file_rdata_in);
      if (!k[7]) w = y;
      chk({file_we_out, carry_out, working_reg_out}, {k[7], c, w});
      if (k[7]) chk({file_addr_out, file_wdata_out}, {k[6:0], y});
      if (i % 8 == 7) begin
        instr_valid_in = 0; push_addr_in = $random(seed); push_in = 1; tick;
        push_in = 0; tick;
        go(i[3] ? 14'h0008 : {6'h34, ~w});
        instr_valid_in = 0; w = i[3] ? w : ~w; tick;
        chk({pc_load_out, pc_out, carry_out, working_reg_out},
          {1'b1, push_addr_in, c, w});
        tick;
      end
    end
    go(14'h0063);
    instr_valid_in = 0;
    chk({timeout_status_bit_out, powerdown_status_bit_out,
      watchdog_counter_out, watchdog_prescaler_out, sleep_out, osc_stop_out,
      carry_out}, {18'h20000, 2'h3, c});
    wake_in = 1; tick;
    chk(sleep_out, 0);
    tally_and_finish;
  end
endmodule
